// ==== hdl/swdm_ctl.v ====
/*
  single-wire debug monitor control: serial time-out and sync answer,
  soft-reset on clock restart, step sequencing, instruction tagging.
  assumes a serial decoder reports bit and command progress, and the
  core reports step, interrupt and queue events, all on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swdm_defs.vh"
module swdm_ctl (
  input wire ref_clk,
  input wire rst_b,
  input wire serial_clk_en,
  input wire background_pin_in,
  output reg background_pin_out,
  output reg background_pin_oe,
  input wire low_byte_strobe_in,
  input wire external_bus_clock,
  input wire low_strobe_enabled,
  input wire transfer_incomplete,
  input wire read_pending,
  input wire ack_pulse_issued,
  input wire ack_enable_cmd,
  input wire ack_disable_cmd,
  input wire cmd_done,
  input wire single_step_command,
  input wire tag_and_go_command,
  input wire interrupt_pending,
  input wire core_instr_retired,
  input wire core_stack_done,
  input wire queue_load,
  input wire queue_advance,
  input wire clock_restart_wait,
  input wire clock_restart_stop,
  input wire stop_mode,
  input wire enter_monitor_req,
  output wire cmd_accept,
  output reg bit_pulse,
  output reg soft_reset,
  output reg debug_monitor_mode,
  output reg tagging_active,
  output reg ack_enabled,
  output reg core_release,
  output reg core_stack_only,
  output reg sync_busy
);
  // one-hot serial line states
  localparam [4:0] ST_IDLE = 5'h01; // waiting for falling edge
  localparam [4:0] ST_LOW = 5'h02; // pin held low, measuring
  localparam [4:0] ST_SYNCW = 5'h04; // sync seen, wait rise
  localparam [4:0] ST_DELAY = 5'h08; // pause before answer
  localparam [4:0] ST_DRIVE = 5'h10; // answer low or pulse
  // one-hot step states
  localparam [2:0] SP_IDLE = 3'h1;
  localparam [2:0] SP_RUN = 3'h2;
  localparam [2:0] SP_STACK = 3'h4;

  wire pin_s; // synchronised background pin
  wire strobe_s; // synchronised low strobe pin
  wire external_bus_clock_s; // synchronised bus clock
  reg pin_d_r; // previous pin sample
  reg external_bus_clock_d_r; // previous bus clock sample
  reg [4:0] st_r; // line state
  reg [4:0] st_nxt;
  reg [`SWDM_CNT_W-1:0] cnt_r; // serial clock counter
  reg [`SWDM_CNT_W-1:0] cnt_nxt;
  reg [`SWDM_CNT_W-1:0] idle_r; // cycles since last fall
  reg pulse_r; // answer in high pulse phase
  reg pulse_nxt;
  reg [2:0] sp_r; // step state
  reg [1:0] tag_smp_r; // sampled tag code
  reg tag_load_r; // tag code valid this fetch
  wire [1:0] head_tag; // tag at queue head
  wire pin_fall; // falling edge on pin
  wire pin_rise; // rising edge on pin
  wire external_bus_clock_fall; // bus clock fall
  wire timeout_armed; // time-out applies now
  wire timeout_hit; // idle exceeded limit
  wire clock_restart; // restart after wait or stop

  // pin inputs pass two flip-flops
  swdm_sync2 #(.W(3), .INIT(1'h1)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({background_pin_in, low_byte_strobe_in, external_bus_clock}),
    .q({pin_s, strobe_s, external_bus_clock_s})
  );

  // tag tracker through the instruction queue
  swdm_tag_queue u_queue (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(debug_monitor_mode),
    .load(queue_load & tag_load_r),
    .load_tag(tag_smp_r),
    .advance(queue_advance),
    .head_tag(head_tag)
  );

  assign pin_fall = pin_d_r & ~pin_s & ~background_pin_oe;
  assign pin_rise = ~pin_d_r & pin_s;
  assign external_bus_clock_fall = external_bus_clock_d_r & ~external_bus_clock_s;
  assign clock_restart = clock_restart_wait | clock_restart_stop;
  // read wait is exempt while handshake is on until acknowledge
  assign timeout_armed = transfer_incomplete &
    ~(read_pending & ack_enabled & ~ack_pulse_issued);
  assign timeout_hit = serial_clk_en & timeout_armed & (st_r == ST_IDLE) &
    (idle_r >= `SWDM_TIMEOUT_CYC - 10'h001);
  // commands refused while tagging or sync is in progress
  assign cmd_accept = ~tagging_active & (st_r == ST_IDLE) & ~stop_mode;

  // edge history
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_d_r <= 1'h1;
      external_bus_clock_d_r <= 1'h1;
    end else begin
      pin_d_r <= pin_s;
      external_bus_clock_d_r <= external_bus_clock_s;
    end
  end

  // idle counter restarts on each fall, counts serial clocks
  always @(posedge ref_clk) begin
    if (!rst_b || soft_reset) begin
      idle_r <= {`SWDM_CNT_W{1'h0}};
    end else if (pin_fall) begin
      idle_r <= {`SWDM_CNT_W{1'h0}};
    end else if (serial_clk_en && !timeout_armed) begin
      idle_r <= {`SWDM_CNT_W{1'h0}};
    end else if (serial_clk_en && idle_r != `SWDM_TIMEOUT_CYC) begin
      idle_r <= idle_r + 10'h001;
    end
  end

  // line state next value
  always @* begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    pulse_nxt = pulse_r;
    case (st_r)
      ST_IDLE: begin
        if (pin_fall && !tagging_active) begin
          st_nxt = ST_LOW;
          cnt_nxt = {`SWDM_CNT_W{1'h0}};
        end
      end
      ST_LOW: begin
        if (pin_rise) begin
          st_nxt = ST_IDLE; // short pulse is a bit
        end else if (serial_clk_en) begin
          if (cnt_r >= `SWDM_SYNC_LOW_CYC) begin
            st_nxt = ST_SYNCW;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
      end
      ST_SYNCW: begin
        if (pin_s) begin
          st_nxt = ST_DELAY; // waits with no limit
          cnt_nxt = {`SWDM_CNT_W{1'h0}};
        end
      end
      ST_DELAY: begin
        if (serial_clk_en) begin
          if (cnt_r == `SWDM_SYNC_DELAY_CYC - 10'h001) begin
            st_nxt = ST_DRIVE;
            cnt_nxt = {`SWDM_CNT_W{1'h0}};
            pulse_nxt = 1'h0;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
      end
      ST_DRIVE: begin
        if (serial_clk_en) begin
          if (pulse_r) begin
            st_nxt = ST_IDLE; // release after pulse
            pulse_nxt = 1'h0;
          end else if (cnt_r == `SWDM_SYNC_DRIVE_CYC - 10'h001) begin
            pulse_nxt = 1'h1;
          end else begin
            cnt_nxt = cnt_r + 10'h001;
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // line state register; stop mode holds port idle
  always @(posedge ref_clk) begin
    if (!rst_b || stop_mode || clock_restart) begin
      st_r <= ST_IDLE;
      cnt_r <= {`SWDM_CNT_W{1'h0}};
      pulse_r <= 1'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // pin drive, bit report, soft-reset and sync status
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      background_pin_out <= 1'h1;
      background_pin_oe <= 1'h0;
      bit_pulse <= 1'h0;
      soft_reset <= 1'h0;
      sync_busy <= 1'h0;
    end else begin
      background_pin_out <= (st_nxt == ST_DRIVE) & pulse_nxt;
      background_pin_oe <= (st_nxt == ST_DRIVE) & ~stop_mode & ~clock_restart;
      bit_pulse <= (st_r == ST_LOW) & pin_rise;
      // sync detect, time-out and clock restart all discard
      soft_reset <= ((st_r == ST_LOW) & (st_nxt == ST_SYNCW)) |
        timeout_hit | clock_restart;
      sync_busy <= (st_nxt != ST_IDLE) & (st_nxt != ST_LOW);
    end
  end

  // acknowledge handshake enable
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      ack_enabled <= 1'h0;
    end else if (clock_restart) begin
      ack_enabled <= 1'h0;
    end else if (ack_disable_cmd) begin
      ack_enabled <= 1'h0;
    end else if (ack_enable_cmd) begin
      ack_enabled <= 1'h1;
    end
  end

  // tag sampling at bus clock fall; low tag gated by strobe mode
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tag_smp_r <= `SWDM_TAG_NONE;
      tag_load_r <= 1'h0;
    end else if (external_bus_clock_fall && tagging_active) begin
      tag_smp_r[1] <= ~pin_s;
      tag_smp_r[0] <= ~strobe_s & low_strobe_enabled;
      tag_load_r <= 1'h1;
    end else if (queue_load || !tagging_active) begin
      tag_load_r <= 1'h0;
    end
  end

  // tagging mode: set by tag-and-go, cleared when monitor enters
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      tagging_active <= 1'h0;
    end else if (clock_restart) begin
      tagging_active <= 1'h0; // restart clears tagging too
    end else if (debug_monitor_mode && tag_and_go_command) begin
      tagging_active <= 1'h1; // pins become tag inputs
    end else if (debug_monitor_mode) begin
      tagging_active <= 1'h0;
    end
  end

  // step sequencing and monitor state
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sp_r <= SP_IDLE;
      debug_monitor_mode <= 1'h0;
      core_release <= 1'h0;
      core_stack_only <= 1'h0;
    end else begin
      core_release <= 1'h0;
      core_stack_only <= 1'h0;
      case (sp_r)
        SP_IDLE: begin
          if (debug_monitor_mode && single_step_command) begin
            debug_monitor_mode <= 1'h0;
            if (interrupt_pending) begin
              sp_r <= SP_STACK;
              core_stack_only <= 1'h1;
            end else begin
              sp_r <= SP_RUN;
              core_release <= 1'h1;
            end
          end else if (debug_monitor_mode && tag_and_go_command) begin
            debug_monitor_mode <= 1'h0;
            core_release <= 1'h1;
          end else if (head_tag != `SWDM_TAG_NONE || enter_monitor_req) begin
            debug_monitor_mode <= 1'h1;
          end
        end
        SP_RUN: begin
          if (core_instr_retired) begin
            sp_r <= SP_IDLE; // back after one instruction
            debug_monitor_mode <= 1'h1;
          end
        end
        SP_STACK: begin
          if (core_stack_done) begin
            sp_r <= SP_IDLE; // pc at service routine
            debug_monitor_mode <= 1'h1;
          end
        end
        default: begin
          sp_r <= SP_IDLE;
        end
      endcase
    end
  end
endmodule // swdm_ctl
`default_nettype wire

// ==== hdl/swdm_defs.vh ====
/*
  constants for the single-wire debug monitor control block:
  serial time-out thresholds, sync answer timing, tag codes.
  assumes it is included by bare name from the control and tag queue design files.
*/
// Operation
// - step command runs exactly one user instruction
// - pending interrupt on step: stack only
// - tag rides queue, enters monitor at head
// - monitor active disables tagging; tagging blocks commands
// - tag-and-go turns strobe and background into tags
// - tags sampled low at bus clock fall
// - two tag inputs act independently
// - low tag only when low strobe enabled
// - low over 128 cycles means sync request
// - no time-out while waiting sync rising edge
// - short pulse is bit; 512 idle soft-resets
// - no handshake: unfetched read data times out
// - handshake on: read time-out suspended
// - after acknowledge, 512 cycle fetch window
// - after soft-reset next fall starts fresh
// - wait-mode clock restart soft-resets, acknowledge off
// - stop shuts port; restart soft-resets, acknowledge off
// - sync answer: 16 wait, 128 low, pulse
// - acknowledge handshake disabled after reset
`ifndef SWDM_DEFS_VH
`define SWDM_DEFS_VH
`define SWDM_CNT_W 10
`define SWDM_SYNC_LOW_CYC 10'h080
`define SWDM_TIMEOUT_CYC 10'h200
`define SWDM_SYNC_DELAY_CYC 10'h010
`define SWDM_SYNC_DRIVE_CYC 10'h080
`define SWDM_QUEUE_DEPTH 3
`define SWDM_TAG_NONE 2'h0
`define SWDM_TAG_LO 2'h1
`define SWDM_TAG_HI 2'h2
`endif

// ==== hdl/swdm_sync2.v ====
/*
  two flip-flop synchroniser, parameter width.
  assumes the input comes from another clock domain or a pin.
*/
`timescale 1ns/1ps
`default_nettype none
module swdm_sync2 #(
  parameter W = 1,
  parameter [0:0] INIT = 1'h1
) (
  input wire ref_clk,
  input wire rst_b,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r; // first stage, read only by second
  // two-stage capture
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      meta_r <= {W{INIT}};
      q <= {W{INIT}};
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // swdm_sync2
`default_nettype wire

// ==== hdl/swdm_tag_queue.v ====
/*
  instruction queue tag tracker: each queue slot keeps two tag bits.
  assumes advance pulses from the core fetch logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swdm_defs.vh"
module swdm_tag_queue (
  input wire ref_clk,
  input wire rst_b,
  input wire flush,
  input wire load,
  input wire [1:0] load_tag,
  input wire advance,
  output reg [1:0] head_tag
);
  reg [1:0] slot_r [0:`SWDM_QUEUE_DEPTH-1]; // tags per queue slot
  genvar g;
  // tags shift toward the head together with their words
  generate
    for (g = 0; g < `SWDM_QUEUE_DEPTH; g = g + 1) begin : g_slot
      if (g == `SWDM_QUEUE_DEPTH-1) begin : g_tail
        // tail slot takes the tag of the word entering the queue
        always @(posedge ref_clk) begin
          if (!rst_b || flush) begin
            slot_r[g] <= `SWDM_TAG_NONE;
          end else if (advance) begin
            slot_r[g] <= load ? load_tag : `SWDM_TAG_NONE;
          end else if (load) begin
            slot_r[g] <= load_tag;
          end
        end
      end else begin : g_body
        // inner slots take the tag behind them on each shift
        always @(posedge ref_clk) begin
          if (!rst_b || flush) begin
            slot_r[g] <= `SWDM_TAG_NONE;
          end else if (advance) begin
            slot_r[g] <= slot_r[g+1];
          end
        end
      end
    end
  endgenerate
  // registered head tag
  always @(posedge ref_clk) begin
    if (!rst_b || flush) begin
      head_tag <= `SWDM_TAG_NONE;
    end else begin
      head_tag <= advance ? slot_r[1] : slot_r[0];
    end
  end
endmodule // swdm_tag_queue
`default_nettype wire

// ==== verif/swdm_ctl_properties.sv ====
/*
  port checker for swdm_ctl: step, tagging, restart and sync answer.
  assumes it is bound to every swdm_ctl instance and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module swdm_ctl_properties (
  input wire ref_clk,
  input wire rst_b,
  input wire single_step_command,
  input wire interrupt_pending,
  input wire clock_restart_wait,
  input wire clock_restart_stop,
  input wire stop_mode,
  input wire cmd_accept,
  input wire debug_monitor_mode,
  input wire tagging_active,
  input wire ack_enabled,
  input wire core_release,
  input wire core_stack_only,
  input wire background_pin_out,
  input wire background_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // a step command that the monitor takes
  wire step_ok = single_step_command && cmd_accept && debug_monitor_mode;
  step_release_a: assert property (
    step_ok && !interrupt_pending |=> core_release && !core_stack_only && !debug_monitor_mode)
    else $error("step did not release the core");
  step_stack_a: assert property (
    step_ok && interrupt_pending |=> core_stack_only && !core_release)
    else $error("step with interrupt ran an instruction");
  tag_block_a: assert property (tagging_active |-> !cmd_accept)
    else $error("command taken while tagging");
  monitor_untag_a: assert property (
    $rose(debug_monitor_mode) |-> ##[0:1] !tagging_active)
    else $error("tagging kept on in monitor");
  stop_idle_a: assert property (stop_mode |-> !cmd_accept)
    else $error("command taken in stop");
  wait_restart_a: assert property (clock_restart_wait |=> !ack_enabled)
    else $error("acknowledge left on after wait restart");
  stop_restart_a: assert property (clock_restart_stop |=> !ack_enabled)
    else $error("acknowledge left on after stop restart");
  reset_ack_a: assert property ($rose(rst_b) |-> !ack_enabled)
    else $error("acknowledge on after reset");
  sync_release_a: assert property (
    $fell(background_pin_oe) |-> $past(background_pin_out))
    else $error("pin released without high pulse");
  // main scenarios reached
  cover property (core_release);
  cover property (core_stack_only);
  cover property ($fell(background_pin_oe));
endmodule // swdm_ctl_properties
bind swdm_ctl swdm_ctl_properties chk_u (.ref_clk, .rst_b, .single_step_command,
  .interrupt_pending, .clock_restart_wait, .clock_restart_stop, .stop_mode, .cmd_accept,
  .debug_monitor_mode, .tagging_active, .ack_enabled, .core_release, .core_stack_only,
  .background_pin_out, .background_pin_oe);
`default_nettype wire

// ==== verif/swdm_host_pod.sv ====
/*
  debug host pod model on the background pin.
  assumes an open-drain wire with pull-up shared with the target.
*/
`timescale 1ns/1ps
`default_nettype none
module swdm_host_pod (
  input wire ref_clk,
  input wire serial_clk_en,
  input wire pin_oe,
  input wire pin_out,
  output wire pin
);
  logic host_low = 1'b0; // host pulls the wire low
  int low_cnt = 0; // enables with target driving low
  logic hi_seen = 1'b0; // target speedup pulse seen
  // wired low wins, released line floats high
  assign pin = !(host_low || (pin_oe && !pin_out));
  // tally of the target answer
  always @(posedge ref_clk) begin
    if (serial_clk_en && pin_oe && !pin_out) low_cnt <= low_cnt + 1;
    if (pin_oe && pin_out) hi_seen <= 1'b1;
  end
  // low pulse of n serial enables, opened by a fall
  task pulse(input int n);
    @(posedge ref_clk) host_low <= 1'b1;
    repeat (n) begin
      do @(posedge ref_clk); while (!serial_clk_en);
    end
    @(posedge ref_clk) host_low <= 1'b0;
  endtask
  // tag level on the shared pin, low asks for a tag
  task hold(input logic v);
    @(posedge ref_clk) host_low <= v;
  endtask
endmodule // swdm_host_pod
`default_nettype wire

// ==== verif/test_single_wire_debug_monitor_ctl.sv ====
/*
  testbench for swdm_ctl: time-outs, sync answer, step, tags, restarts.
  assumes the host pod model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_single_wire_debug_monitor_ctl;
  logic ref_clk = 0, rst_b = 0, se = 0, strobe = 1, ebc = 1, lse = 0, tinc = 0, rdp = 0;
  logic acki = 0, acke = 0, ackd = 0, step = 0, tgo = 0, irq = 0, ret = 0, stk = 0, ql = 0;
  logic qa = 0, rw = 0, rs = 0, stp = 0, emr = 0;
  wire pin, pout, poe, acc, bp, sr, mon, tag, acken, rel, sto, sb;
  int errors = 0, checked = 0, cyc = 0, at, bb, k, j, n;
  always #12.5 ref_clk = ~ref_clk;
  // serial enable every other cycle, plus hang guard
  always @(posedge ref_clk) begin
    se <= ~se;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      finish_test;
    end
  end
  swdm_ctl dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .serial_clk_en(se),
    .background_pin_in(pin), .background_pin_out(pout), .background_pin_oe(poe),
    .low_byte_strobe_in(strobe), .external_bus_clock(ebc), .low_strobe_enabled(lse),
    .transfer_incomplete(tinc), .read_pending(rdp), .ack_pulse_issued(acki),
    .ack_enable_cmd(acke), .ack_disable_cmd(ackd), .cmd_done(1'b0),
    .single_step_command(step), .tag_and_go_command(tgo), .interrupt_pending(irq),
    .core_instr_retired(ret), .core_stack_done(stk), .queue_load(ql), .queue_advance(qa),
    .clock_restart_wait(rw), .clock_restart_stop(rs), .stop_mode(stp),
    .enter_monitor_req(emr), .cmd_accept(acc), .bit_pulse(bp), .soft_reset(sr),
    .debug_monitor_mode(mon), .tagging_active(tag), .ack_enabled(acken),
    .core_release(rel), .core_stack_only(sto), .sync_busy(sb));
  swdm_host_pod pod_u (.ref_clk(ref_clk), .serial_clk_en(se), .pin_oe(poe),
    .pin_out(pout), .pin(pin));
  // compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle pulse on a command input chosen by index
  task pls(input int s);
    @(posedge ref_clk);
    case (s)
      0: emr <= 1; 1: step <= 1; 2: tgo <= 1; 3: ret <= 1; 4: stk <= 1; 5: ql <= 1;
      6: qa <= 1; 7: acke <= 1; 8: ackd <= 1; 9: rw <= 1; default: rs <= 1;
    endcase
    @(posedge ref_clk) {emr, step, tgo, ret, stk, ql, qa, acke, ackd, rw, rs} <= 0;
    #1;
  endtask
  // first cycle of soft reset and bit pulse over c cycles
  task watch(input int c);
    at = -1;
    bb = -1;
    for (k = 0; k < c; k++) begin
      @(posedge ref_clk);
      #1;
      if (sr === 1'b1 && at < 0) at = k;
      if (bp === 1'b1 && bb < 0) bb = k;
    end
  endtask
  // tag expected from pin levels and strobe mode
  function logic [1:0] exp_tag(input logic hi, input logic lo, input logic en);
    return {hi, lo & en};
  endfunction
  task finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(11488));
    repeat (6) @(posedge ref_clk);
    rst_b <= 1;
    tick(4);
    chk(acken, 0);
    chk(poe, 0);
    // short bit while armed, then idle time-out, then unarmed idle
    for (j = 0; j < 2; j++) begin
      n = 5 + $urandom % 100;
      @(posedge ref_clk) tinc <= !j;
      pod_u.pulse(n);
      watch(1200);
      chk(bb >= 0 && bb < 8, 1);
      chk(j ? at : (at >= 1010 - 2 * n && at <= 1034 - 2 * n), j ? -1 : 1);
    end
    $display("test time-out done");
    // read with and without handshake
    pls(7);
    chk(acken, 1);
    @(posedge ref_clk) begin
      rdp <= 1;
      tinc <= 1;
    end
    watch(1500);
    chk(at, -1);
    @(posedge ref_clk) acki <= 1;
    watch(1100);
    chk(at >= 1000 && at < 1040, 1);
    @(posedge ref_clk) acki <= 0;
    pls(8);
    chk(acken, 0);
    watch(1100);
    chk(at >= 1000 && at < 1040, 1);
    @(posedge ref_clk) begin
      rdp <= 0;
      tinc <= 0;
    end
    $display("test read done");
    // sync request held long, then the timed answer
    pod_u.low_cnt = 0;
    fork
      pod_u.pulse(1000);
      watch(2000);
    join
    #1;
    chk(at >= 255 && at <= 270, 1);
    chk(poe, 0);
    chk(sb, 1);
    n = 0;
    while (poe !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(n >= 30 && n <= 44, 1);
    tick(300);
    chk(sb, 0);
    chk(pod_u.low_cnt, 128);
    chk(pod_u.hi_seen, 1);
    $display("test sync done");
    // step with and without pending interrupt
    for (j = 0; j < 2; j++) begin
      @(posedge ref_clk) irq <= j;
      pls(0);
      tick(2);
      chk(mon, 1);
      pls(1);
      chk(rel, !j);
      chk(sto, j);
      chk(mon, 0);
      pls(j ? 4 : 3);
      tick(1);
      chk(mon, 1);
    end
    @(posedge ref_clk) irq <= 0;
    $display("test step done");
    // all four pin level pairs in both strobe modes
    for (j = 0; j < 8; j++) begin
      if (mon !== 1'b1) pls(0);
      pls(2);
      tick(2);
      chk(tag, 1);
      chk(acc, 0);
      @(posedge ref_clk) begin
        lse <= j[2];
        strobe <= ~j[1];
      end
      pod_u.hold(j[0]);
      tick(3);
      @(posedge ref_clk) ebc <= 0;
      tick(4);
      pls(5);
      @(posedge ref_clk) begin
        ebc <= 1;
        strobe <= 1;
      end
      pod_u.hold(0);
      repeat (3) pls(6);
      tick(4);
      chk(mon, exp_tag(j[0], j[1], j[2]) != 2'h0);
    end
    $display("test tag done");
    // clock restart after wait and after stop
    for (j = 0; j < 2; j++) begin
      pls(7);
      @(posedge ref_clk) stp <= j;
      tick(1);
      if (j) chk(acc, 0);
      fork
        pls(9 + j);
        watch(6);
      join
      chk(at >= 0, 1);
      chk(acken, 0);
      @(posedge ref_clk) stp <= 0;
    end
    $display("test restart done");
    finish_test;
  end
endmodule // test_single_wire_debug_monitor_ctl
`default_nettype wire
